//--- design/hst_hop_tracker.sv
`timescale 1ns/100ps
module hst_hop_tracker
  import hst_pkg::*;
#(
  parameter int SLOT_CYCLES = SLOT_CYC
)(
  input  wire logic  clock,
  input  wire logic  reset,
  input  wire logic  hop_sync,
  input  wire logic  hop_detect_enable,
  hst_hop_if.tracker hop
);
  logic [2:0]       sync_q;
  logic             level_q;
  logic             rise;
  logic [CNT_W-1:0] since_hop_q;
  logic [CNT_W-1:0] period_q;
  logic             period_ok_q;
  logic [CNT_W-1:0] slot_q;
  logic             predicted;
  logic             slot_edge;
  logic [CNT_W-1:0] quiet_q;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      sync_q <= 3'h0;
    else
      sync_q <= {sync_q[1:0], hop_sync};
  end

  // [R10] Hop sync monitor
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      level_q <= 1'b0;
    else if (sync_q[1] == sync_q[2])
      level_q <= sync_q[2];
  end
  assign rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !level_q;

  // [R7] Prediction fills a missed hop
  assign predicted = period_ok_q && (since_hop_q == period_q);

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      since_hop_q <= CNT_ZERO;
      period_q    <= CNT_ZERO;
      period_ok_q <= 1'b0;
    end
    else if (!hop_detect_enable)
    begin
      since_hop_q <= CNT_ZERO;
      period_ok_q <= 1'b0;
    end
    else if (rise)
    begin
      since_hop_q <= CNT_ONE;
      period_q    <= since_hop_q;
      period_ok_q <= since_hop_q != CNT_ZERO;
    end
    // Give up prediction once real hops stop; predictions alone never renew it
    else if (quiet_q == CNT_W'(SLOT_CYCLES) * 24'h000008)
    begin
      since_hop_q <= CNT_ZERO;
      period_ok_q <= 1'b0;
    end
    else if (predicted)
      since_hop_q <= CNT_ONE;
    else
      since_hop_q <= since_hop_q + CNT_ONE;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      quiet_q <= CNT_ZERO;
    else if (!hop_detect_enable || rise)
      quiet_q <= CNT_ZERO;
    else if (quiet_q != CNT_W'(SLOT_CYCLES) * 24'h000008)
      quiet_q <= quiet_q + CNT_ONE;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      slot_q <= CNT_ZERO;
    else if (slot_edge)
      slot_q <= CNT_ZERO;
    else
      slot_q <= slot_q + CNT_ONE;
  end
  assign slot_edge = slot_q == CNT_W'(SLOT_CYCLES - 1);

  // [R11] Every slot a boundary without hop info
  assign hop.boundary     = period_ok_q ? (rise || predicted) : (rise || slot_edge);
  assign hop.hop_seen     = rise;
  assign hop.dwell_known  = period_ok_q;
  assign hop.dwell_cycles = period_q;
endmodule

//--- design/hst_timing.sv
`timescale 1ns/100ps
module hst_timing
  import hst_pkg::*;
#(
  parameter int SLOT_CYCLES     = SLOT_CYC,
  parameter int RHD_BASE_CYCLES = RHD_BASE_CYC,
  parameter int S_SINGLE_CYCLES = S_SINGLE_CYC,
  parameter int S_MULTI_CYCLES  = S_MULTI_CYC,
  parameter int TDC_CYCLES      = TDC_EXTRA_CYC,
  parameter int TRANSMISSION_SECURITY_CYCLES  = TRANSMISSION_SECURITY_CYC,
  parameter int TP_BASE_CYCLES  = TP_BASE_CYC
)(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  hop_sync,
  input  wire logic                  hop_detect_enable,
  input  wire logic [hst_pkg::CFG_W-1:0] long_dwell_config_value,
  input  wire logic                  fec_enable,
  input  wire logic                  time_dispersive_coding,
  input  wire logic                  tx_request,
  input  wire logic                  tx_done,
  input  wire logic                  rx_multi_dwell,
  input  wire logic                  rx_end_flag,
  output logic                       tx_start,
  output logic                       tx_active,
  output logic                       ack_multi_dwell,
  output logic                       hop_boundary,
  output logic [hst_pkg::CNT_W-1:0]  last_bit_time,
  output logic                       last_bit_valid,
  output logic                       rhd_running,
  output logic                       rhd_expired,
  output logic                       timeout_running,
  output logic                       timeout_expired
);
  hst_hop_if hop ();

  hst_hop_tracker #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_tracker (
    .clock             (clock),
    .reset             (reset),
    .hop_sync          (hop_sync),
    .hop_detect_enable (hop_detect_enable),
    .hop               (hop)
  );

  hst_tx_state_t    state_q;
  logic [CFG_W-1:0] long_left_q;
  logic             long_avail;
  logic [CNT_W-1:0] now_q;
  logic [CNT_W-1:0] stamp_q;
  logic             stamp_pend_q;
  logic [CNT_W-1:0] s_term;
  logic [CNT_W-1:0] rhd_total;
  logic [CNT_W-1:0] tp_total;
  logic [CNT_W-1:0] elapsed;
  logic [CNT_W-1:0] rhd_q;
  logic [CNT_W-1:0] tp_q;
  logic             rhd_exp_q;
  logic             tp_exp_q;
  logic             start_q;

  assign hop_boundary = hop.boundary;

  // [R3] Long dwell from configured value
  assign long_avail      = long_dwell_config_value != CFG_ZERO;
  assign ack_multi_dwell = !long_avail;

  // [R7] Start only on hop boundary
  // [R4] Skip past guaranteed long dwell
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_q     <= HST_IDLE;
      long_left_q <= CFG_ZERO;
    end
    else
    begin
      unique case (state_q)
        HST_IDLE:
        begin
          if (tx_request)
            state_q <= HST_SYNC;
        end
        HST_SYNC:
        begin
          if (hop.boundary)
          begin
            long_left_q <= long_dwell_config_value;
            state_q     <= long_avail ? HST_LONG : HST_SEND;
          end
        end
        HST_LONG:
        begin
          // Bit sync time is loose, so the long dwell carries no data
          if (hop.boundary)
          begin
            long_left_q <= long_left_q - CFG_ONE;
            if (long_left_q == CFG_ONE)
              state_q <= HST_SEND;
          end
        end
        HST_SEND:
        begin
          if (tx_done)
            state_q <= HST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      start_q <= 1'b0;
    else
      start_q <= (state_q != HST_SEND) && (state_q != HST_IDLE) && hop.boundary
                 && ((state_q == HST_SYNC && !long_avail)
                 || (state_q == HST_LONG && long_left_q == CFG_ONE));
  end
  assign tx_start  = start_q;
  assign tx_active = state_q == HST_SEND;

  // [R12] Free-running timestamp counter
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      now_q <= CNT_ZERO;
    else
      now_q <= now_q + CNT_ONE;
  end

  // A flag in the load cycle is dropped, so flags need two cycles apart
  // [R6] Stamp final multi-dwell bit
  // [R9] Sync point is final frame flag
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      stamp_q      <= CNT_ZERO;
      stamp_pend_q <= 1'b0;
      last_bit_valid <= 1'b0;
    end
    else if (rx_end_flag && !stamp_pend_q)
    begin
      stamp_q        <= now_q;
      stamp_pend_q   <= 1'b1;
      last_bit_valid <= rx_multi_dwell;
    end
    else
      // [R12] Held until timers load
      stamp_pend_q <= 1'b0;
  end
  assign last_bit_time = stamp_q;

  // [R8] Inflated per-response term
  // [R1] Network-wide length terms
  always_comb
  begin
    s_term = ack_multi_dwell ? CNT_W'(S_MULTI_CYCLES) : CNT_W'(S_SINGLE_CYCLES);
    if (fec_enable)
      s_term = {s_term[CNT_W-2:0], 1'b0};
    if (time_dispersive_coding)
      s_term = s_term + CNT_W'(TDC_CYCLES);
  end

  // [R2] Worst-case hop delay if dwell unknown
  assign rhd_total = CNT_W'(RHD_BASE_CYCLES) + s_term
                   + (hop.dwell_known ? CNT_ZERO : CNT_W'(TRANSMISSION_SECURITY_CYCLES));
  assign tp_total  = CNT_W'(TP_BASE_CYCLES) + rhd_total;

  // Loading costs one cycle, so the elapsed count is taken off
  // [R5] Both timers from last-bit time
  assign elapsed = now_q - stamp_q;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      rhd_q     <= CNT_ZERO;
      rhd_exp_q <= 1'b0;
    end
    else if (stamp_pend_q)
    begin
      rhd_q     <= rhd_total - elapsed;
      rhd_exp_q <= 1'b0;
    end
    else
    begin
      rhd_exp_q <= rhd_q == CNT_ONE;
      if (rhd_q != CNT_ZERO)
        rhd_q <= rhd_q - CNT_ONE;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      tp_q     <= CNT_ZERO;
      tp_exp_q <= 1'b0;
    end
    else if (stamp_pend_q)
    begin
      tp_q     <= tp_total - elapsed;
      tp_exp_q <= 1'b0;
    end
    else
    begin
      tp_exp_q <= tp_q == CNT_ONE;
      if (tp_q != CNT_ZERO)
        tp_q <= tp_q - CNT_ONE;
    end
  end

  assign rhd_running     = rhd_q != CNT_ZERO;
  assign rhd_expired     = rhd_exp_q;
  assign timeout_running = tp_q != CNT_ZERO;
  assign timeout_expired = tp_exp_q;
endmodule

//--- include/hst_hop_if.sv
`timescale 1ns/100ps
interface hst_hop_if;
  logic                      boundary;
  logic                      hop_seen;
  logic                      dwell_known;
  logic [hst_pkg::CNT_W-1:0] dwell_cycles;
  modport tracker (output boundary, output hop_seen, output dwell_known, output dwell_cycles);
  modport timing  (input boundary, input hop_seen, input dwell_known, input dwell_cycles);
endinterface

//--- include/hst_pkg.sv
// Overview of operation
// [R1] Response length terms come from network configuration, identical at every node.
// [R2] Unknown dwell length adds worst-case hop-every-slot security delays.
// [R3] Configured long-dwell value decides long-dwell availability and acknowledgment method.
// [R4] Data transmission starts on the first hop dwell after the guaranteed long dwell.
// [R5] Final received bit arrival time references both hold and timeout timers.
// [R6] Physical layer timestamps the final bit of each multi-dwell reception.
// [R7] Transmit start aligns to hops using hop detection and hop prediction.
// [R8] Multi-dwell hold delay inflates per-response term, fixed Type 3 frame, worst hop rate.
// [R9] Timeout sync point is the final frame flag ending the reception.
// [R10] Hops are detected by monitoring the radio hop synchronization output.
// [R11] Without hop timing information every time slot counts as a hop boundary.
// [R12] Timestamp comes from a free-running counter, held until timers load it.
package hst_pkg;
  localparam int CLOCK_HZ = 10000000;
  localparam int CNT_W    = 24;
  localparam int CFG_W    = 8;
  // Times in microseconds
  localparam int SLOT_US          = 1000;
  localparam int RHD_BASE_US      = 20000;
  localparam int S_SINGLE_US      = 50000;
  localparam int S_MULTI_US       = 150000;
  localparam int TDC_EXTRA_US     = 30000;
  localparam int TRANSMISSION_SECURITY_US       = 40000;
  localparam int TP_BASE_US       = 100000;
  localparam int MISS_MARGIN_US   = 100;
  localparam int SLOT_CYC        = SLOT_US * (CLOCK_HZ / 1000000);
  localparam int RHD_BASE_CYC    = RHD_BASE_US * (CLOCK_HZ / 1000000);
  localparam int S_SINGLE_CYC    = S_SINGLE_US * (CLOCK_HZ / 1000000);
  localparam int S_MULTI_CYC     = S_MULTI_US * (CLOCK_HZ / 1000000);
  localparam int TDC_EXTRA_CYC   = TDC_EXTRA_US * (CLOCK_HZ / 1000000);
  localparam int TRANSMISSION_SECURITY_CYC     = TRANSMISSION_SECURITY_US * (CLOCK_HZ / 1000000);
  localparam int TP_BASE_CYC     = TP_BASE_US * (CLOCK_HZ / 1000000);
  localparam int MISS_MARGIN_CYC = MISS_MARGIN_US * (CLOCK_HZ / 1000000);
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;
  localparam logic [CFG_W-1:0] CFG_ZERO = 8'h00;
  localparam logic [CFG_W-1:0] CFG_ONE  = 8'h01;
  typedef enum logic [3:0] {
    HST_IDLE = 4'b0001,
    HST_SYNC = 4'b0010,
    HST_LONG = 4'b0100,
    HST_SEND = 4'b1000
  } hst_tx_state_t;
endpackage

//--- tb/hst_radio_model.sv
`timescale 1ns/100ps
module hst_radio_model #(
  parameter int PERIOD = 40
)(
  input  wire logic clock,
  input  wire logic run,
  output logic      hop_sync = 1'b0
);
  int cnt_q = 0;
  // Hop sync output
  // Held low when stopped, so no stray edge fakes a hop
  always @(negedge clock)
  begin
    cnt_q <= run ? (cnt_q + 1) % PERIOD : 0;
    hop_sync <= run && cnt_q < 4;
  end
endmodule

//--- tb/hst_timing_assertions.sv
`timescale 1ns/100ps
module hst_timing_assertions
  import hst_pkg::*;
#(
  parameter int SLOT_CYCLES = SLOT_CYC
)(
  input wire logic             clock,
  input wire logic             reset,
  input wire logic             hop_sync,
  input wire logic             hop_detect_enable,
  input wire logic [CFG_W-1:0] long_dwell_config_value,
  input wire logic             fec_enable,
  input wire logic             time_dispersive_coding,
  input wire logic             tx_request,
  input wire logic             tx_done,
  input wire logic             rx_multi_dwell,
  input wire logic             rx_end_flag,
  input wire logic             tx_start,
  input wire logic             tx_active,
  input wire logic             ack_multi_dwell,
  input wire logic             hop_boundary,
  input wire logic [CNT_W-1:0] last_bit_time,
  input wire logic             last_bit_valid,
  input wire logic             rhd_running,
  input wire logic             rhd_expired,
  input wire logic             timeout_running,
  input wire logic             timeout_expired
);
  logic [15:0] gap_q;
  // Cleared while hops are tracked, so a stale hop gap never counts
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset || hop_boundary || hop_detect_enable)
      gap_q <= 16'h0000;
    else
      gap_q <= gap_q + 16'h0001;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_hop_rise; hop_detect_enable && $rose(hop_sync); endsequence
  sequence s_flag_load; rx_end_flag ##1 1'b1; endsequence
  property p_hop_seen; s_hop_rise |-> ##[2:5] hop_boundary; endproperty
  a_hop_seen: assert property (p_hop_seen) else $error("hop edge not reported");
  property p_slot_edge; gap_q <= SLOT_CYCLES; endproperty
  a_slot_edge: assert property (p_slot_edge) else $error("slot edge missing");
  property p_start_pulse; tx_start |=> !tx_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_bound; tx_start |-> $past(hop_boundary); endproperty
  a_start_bound: assert property (p_start_bound) else $error("start off hop");
  property p_start_send; tx_start |-> ##[0:1] tx_active; endproperty
  a_start_send: assert property (p_start_send) else $error("start without send");
  property p_hold_send; tx_active && !tx_done |=> tx_active; endproperty
  a_hold_send: assert property (p_hold_send) else $error("send dropped early");
  property p_ack_cfg; ack_multi_dwell == (long_dwell_config_value == CFG_ZERO); endproperty
  a_ack_cfg: assert property (p_ack_cfg) else $error("ack method wrong");
  property p_stamp_kind; s_flag_load |-> last_bit_valid == $past(rx_multi_dwell); endproperty
  a_stamp_kind: assert property (p_stamp_kind) else $error("stamp kind wrong");
  property p_stamp_hold; !rx_end_flag |=> $stable(last_bit_time); endproperty
  a_stamp_hold: assert property (p_stamp_hold) else $error("stamp moved");
  property p_load; s_flag_load |=> rhd_running && timeout_running; endproperty
  a_load: assert property (p_load) else $error("timers not loaded");
  property p_rhd_end; rhd_expired |-> !rhd_running ##1 !rhd_expired; endproperty
  a_rhd_end: assert property (p_rhd_end) else $error("hold expiry wrong");
  property p_tp_end; timeout_expired |-> !timeout_running ##1 !timeout_expired; endproperty
  a_tp_end: assert property (p_tp_end) else $error("timeout expiry wrong");
endmodule
bind hst_timing hst_timing_assertions #(.SLOT_CYCLES(SLOT_CYCLES)) u_checker (
  .clock(clock), .reset(reset), .hop_sync(hop_sync), .hop_detect_enable(hop_detect_enable),
  .long_dwell_config_value(long_dwell_config_value), .fec_enable(fec_enable),
  .time_dispersive_coding(time_dispersive_coding), .tx_request(tx_request),
  .tx_done(tx_done), .rx_multi_dwell(rx_multi_dwell), .rx_end_flag(rx_end_flag),
  .tx_start(tx_start), .tx_active(tx_active), .ack_multi_dwell(ack_multi_dwell),
  .hop_boundary(hop_boundary), .last_bit_time(last_bit_time),
  .last_bit_valid(last_bit_valid), .rhd_running(rhd_running), .rhd_expired(rhd_expired),
  .timeout_running(timeout_running), .timeout_expired(timeout_expired));

//--- tb/test_hop_synced_response_timing.sv
`timescale 1ns/100ps
module test_hop_synced_response_timing;
  import hst_pkg::*;
  logic             clock = 1'b0;
  logic             reset = 1'b1;
  logic             hop_sync;
  logic             hop_detect_enable = 1'b0;
  logic [CFG_W-1:0] long_dwell_config_value = CFG_ZERO;
  logic             fec_enable = 1'b0;
  logic             time_dispersive_coding = 1'b0;
  logic             tx_request = 1'b0;
  logic             tx_done = 1'b0;
  logic             rx_multi_dwell = 1'b0;
  logic             rx_end_flag = 1'b0;
  logic             radio_run = 1'b1;
  logic             tx_start, tx_active, ack_multi_dwell, hop_boundary, last_bit_valid;
  logic             rhd_running, rhd_expired, timeout_running, timeout_expired;
  logic [CNT_W-1:0] last_bit_time, lt1;
  logic [CFG_W-1:0] cfgs [3] = '{8'h00, 8'h01, 8'h03};
  int               miscompares = 0, compares = 0, cyc = 0;
  int               i, a, b, c, d, e, g, t1, t2, t3;
  localparam int    RHD_T = 10, SS_T = 5, TP_T = 30;
  always #50 clock = ~clock;
  // Coding and security extras keep full defaults, so those runs outlast the wait loop
  hst_radio_model u_radio (.clock(clock), .run(radio_run), .hop_sync(hop_sync));
  hst_timing #(.SLOT_CYCLES(20), .RHD_BASE_CYCLES(RHD_T), .S_SINGLE_CYCLES(SS_T),
    .S_MULTI_CYCLES(15), .TP_BASE_CYCLES(TP_T)) u_dut (
    .clock(clock), .reset(reset), .hop_sync(hop_sync), .hop_detect_enable(hop_detect_enable),
    .long_dwell_config_value(long_dwell_config_value), .fec_enable(fec_enable),
    .time_dispersive_coding(time_dispersive_coding), .tx_request(tx_request),
    .tx_done(tx_done), .rx_multi_dwell(rx_multi_dwell), .rx_end_flag(rx_end_flag),
    .tx_start(tx_start), .tx_active(tx_active), .ack_multi_dwell(ack_multi_dwell),
    .hop_boundary(hop_boundary), .last_bit_time(last_bit_time),
    .last_bit_valid(last_bit_valid), .rhd_running(rhd_running), .rhd_expired(rhd_expired),
    .timeout_running(timeout_running), .timeout_expired(timeout_expired));
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  // Counts boundaries between request and start
  task automatic tx_run(input logic [CFG_W-1:0] n);
    int k;
    int nb;
    int last;
    logic seen;
    long_dwell_config_value = n;
    nb = 0;
    last = 0;
    seen = 1'b0;
    tx_request = 1'b1;
    @(negedge clock);
    tx_request = 1'b0;
    for (k = 0; k < 3000 && tx_start !== 1'b1; k++)
    begin
      if (hop_boundary === 1'b1)
      begin
        nb++;
        last = k;
      end
      @(negedge clock);
    end
    check(ack_multi_dwell, n == CFG_ZERO);
    check(nb, n + 1);
    check(k - last, 1);
    @(negedge clock);
    check(tx_active, 1'b1);
    tx_request = 1'b1;
    @(negedge clock);
    tx_request = 1'b0;
    tx_done = 1'b1;
    @(negedge clock);
    tx_done = 1'b0;
    for (k = 0; k < 60; k++)
    begin
      @(negedge clock);
      seen = seen | tx_start;
    end
    check(tx_active, 1'b0);
    check(seen, 1'b0);
  endtask
  task automatic rx_run(input logic multi, output int lat, output int at);
    int nr;
    at = cyc;
    nr = 0;
    rx_multi_dwell = multi;
    rx_end_flag = 1'b1;
    @(negedge clock);
    rx_end_flag = 1'b0;
    @(negedge clock);
    check(last_bit_valid, multi);
    lat = 0;
    repeat (3000)
    begin
      @(negedge clock);
      nr += rhd_expired;
      if (rhd_running !== 1'b1 && timeout_running !== 1'b1)
        break;
      lat += rhd_running + timeout_running;
    end
    // A saturated run never expires inside the wait
    check(nr, lat < 6000);
    check(timeout_expired, lat < 6000);
  endtask
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (16) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    for (i = 0; i < 3; i++)
      tx_run(cfgs[i]);
    $display("test slot start done");
    hop_detect_enable = 1'b1;
    repeat (120) @(negedge clock);
    tx_run(8'h02);
    $display("test hop start done");
    rx_run(1'b0, a, t1);
    // Each timer loses its load cycle and the first sampled cycle
    check(a, 2 * (RHD_T + SS_T) + TP_T - 4);
    lt1 = last_bit_time;
    rx_run(1'b0, b, t2);
    check(b, a);
    check(last_bit_time - lt1, CNT_W'(t2 - t1));
    // Multi-dwell acks follow from a zero long-dwell value
    long_dwell_config_value = CFG_ZERO;
    rx_run(1'b1, c, t3);
    check(c > a, 1'b1);
    long_dwell_config_value = 8'h02;
    fec_enable = 1'b1;
    rx_run(1'b0, d, t3);
    check(d > a, 1'b1);
    fec_enable = 1'b0;
    time_dispersive_coding = 1'b1;
    rx_run(1'b0, e, t3);
    check(e > a, 1'b1);
    time_dispersive_coding = 1'b0;
    hop_detect_enable = 1'b0;
    radio_run = 1'b0;
    repeat (200) @(negedge clock);
    rx_run(1'b0, g, t3);
    check(g > a, 1'b1);
    $display("test receive timers done");
    tally_and_finish();
  end
endmodule
